// ==== dv/host_model.sv ====
// host side model: shift clock and identification reads
`timescale 1ns/1ns
module host_model (
	// control
	input wire logic ref_clk,
	input wire logic clk_run,
	// link and read events
	output logic pixel_shift_clock,
	output logic id_read_start,
	output logic [6:0] id_read_addr,
	output logic id_byte_read,
	output logic id_read_stop
);
	initial begin
		pixel_shift_clock = 0;
		{id_read_start, id_byte_read, id_read_stop} = 3'h0;
		id_read_addr = 7'h00;
	end
	// 15 ns link clock, held low when idle so no stray edges
	always begin
		#7;
		pixel_shift_clock = clk_run;
		#8;
		pixel_shift_clock = 0;
	end
	// address only valid with start, inverse otherwise
	task automatic read_id(input logic [6:0] addr, input int n);
		@(negedge ref_clk);
		{id_read_start, id_read_addr} = {1'b1, addr};
		@(negedge ref_clk);
		{id_read_start, id_read_addr} = {1'b0, ~addr};
		repeat (n) begin
			id_byte_read = 1;
			@(negedge ref_clk);
			id_byte_read = 0;
			@(negedge ref_clk);
		end
		id_read_stop = 1;
		@(negedge ref_clk);
		id_read_stop = 0;
	endtask : read_id
endmodule : host_model

// ==== dv/hotplug_asserts.sv ====
// assertion checker for the hot-plug sequencer
`timescale 1ns/1ns
module hotplug_asserts
	import hotplug_pkg::*;
#(
	parameter int TIMEOUT_CYC = CLK_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// pins
	input wire logic host_supply_sense,
	input wire logic pixel_shift_clock,
	// outputs
	input wire logic receiver_enable,
	input wire logic panel_power,
	input wire logic [1:0] display_power_state,
	input wire logic [3:0] seq_state
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	int unsigned idle_cnt;
	logic link_prev;
	// local cycles with no link edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			link_prev <= 1'b0;
			idle_cnt <= 0;
		end else begin
			link_prev <= pixel_shift_clock;
			if (pixel_shift_clock != link_prev) idle_cnt <= 0;
			else idle_cnt <= idle_cnt + 1;
		end
	end
	off_quiet_a: assert property (seq_state == 4'h1 |-> !receiver_enable && !panel_power
		&& display_power_state == PWR_OFF) else $error("outputs live in off");
	panel_rx_a: assert property (panel_power |-> receiver_enable) else $error("panel w/o rx");
	panel_normal_a: assert property (panel_power == (seq_state == 4'h8)) else $error("panel");
	rx_state_a: assert property (receiver_enable |-> seq_state[2] || seq_state[3])
		else $error("rx outside run states");
	rx_from_wait_a: assert property ($rose(receiver_enable) |-> $past(seq_state) == 4'h2)
		else $error("rx enabled without id read");
	supply_loss_a: assert property ($fell(host_supply_sense) |-> ##[1:5] seq_state == 4'h1)
		else $error("no off after supply loss");
	no_supply_a: assert property (!host_supply_sense [*5] |-> seq_state == 4'h1)
		else $error("active without supply");
	clock_stop_a: assert property (idle_cnt > TIMEOUT_CYC + 8 |-> !panel_power)
		else $error("panel on with link idle");
	power_normal_a: assert property (display_power_state != PWR_OFF |-> seq_state == 4'h8)
		else $error("power state decoded outside normal mode");
endmodule : hotplug_asserts

// ==== dv/monitor_hotplug_power_sequencer_test.sv ====
// self-checking bench for the hot-plug sequencer
`timescale 1ns/1ns
module monitor_hotplug_power_sequencer_test;
	import hotplug_pkg::*;
	logic ref_clk = 0, rst = 1, host_supply_sense = 0, hsync = 0, vsync = 0;
	logic hs_on = 0, vs_on = 0, clk_run = 0;
	logic pixel_shift_clock, id_read_start, id_byte_read, id_read_stop;
	logic receiver_enable, panel_power;
	logic [6:0] id_read_addr;
	logic [1:0] display_power_state;
	logic [3:0] seq_state;
	logic [1:0] ps_tab [4] = '{PWR_OFF, PWR_STANDBY, PWR_SUSPEND, PWR_ON};
	int errors = 0, checks = 0;
	always #5 ref_clk = ~ref_clk;
	always @(negedge ref_clk) begin
		if (hs_on) hsync <= ~hsync;
		if (vs_on) vsync <= ~vsync;
	end
	host_model host (
		.ref_clk(ref_clk),
		.clk_run(clk_run),
		.pixel_shift_clock(pixel_shift_clock),
		.id_read_start(id_read_start),
		.id_read_addr(id_read_addr),
		.id_byte_read(id_byte_read),
		.id_read_stop(id_read_stop)
	);
	monitor_hotplug_power_sequencer #(.TIMEOUT_CYC(20), .SYNC_CYC(50)) dut (
		.ref_clk(ref_clk),
		.rst(rst),
		.host_supply_sense(host_supply_sense),
		.pixel_shift_clock(pixel_shift_clock),
		.hsync(hsync),
		.vsync(vsync),
		.id_read_start(id_read_start),
		.id_read_addr(id_read_addr),
		.id_byte_read(id_byte_read),
		.id_read_stop(id_read_stop),
		.receiver_enable(receiver_enable),
		.panel_power(panel_power),
		.display_power_state(display_power_state),
		.seq_state(seq_state)
	);
	task automatic cmp(input string what, input logic [3:0] exp, input logic [3:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic wait_st(input logic [3:0] s, input int lim);
		for (int i = 0; i < lim && seq_state !== s; i++) @(negedge ref_clk);
		cmp("seq_state", s, seq_state);
	endtask : wait_st
	task automatic t_run_up;
		host.read_id(ID_DEV_ADDR, 256);
		wait_st(4'h4, 6);
		cmp("rx panel", 4'h8, {receiver_enable, panel_power, 2'b00});
		repeat (10) @(negedge ref_clk);
		cmp("seq_state", 4'h4, seq_state);
		clk_run = 1;
		wait_st(4'h8, 10);
		cmp("rx panel", 4'hc, {receiver_enable, panel_power, 2'b00});
	endtask : t_run_up
	task automatic t_discovery;
		host_supply_sense = 1;
		wait_st(4'h2, 10);
		host.read_id(7'h50, 256);
		host.read_id(ID_DEV_ADDR, 255);
		repeat (4) @(negedge ref_clk);
		cmp("seq_state", 4'h2, seq_state);
		{hs_on, vs_on} = 2'b11;
		t_run_up;
		for (int k = 3; k >= 0; k--) begin
			{hs_on, vs_on} = k[1:0];
			repeat (80) @(negedge ref_clk);
			cmp("power state", {2'b00, ps_tab[k]}, {2'b00, display_power_state});
		end
		{hs_on, vs_on} = 2'b11;
	endtask : t_discovery
	task automatic t_clock_loss;
		clk_run = 0;
		repeat (15) @(negedge ref_clk);
		cmp("seq_state", 4'h8, seq_state);
		wait_st(4'h1, 40);
		cmp("outputs", {2'b00, PWR_OFF}, {receiver_enable, panel_power, display_power_state});
		wait_st(4'h2, 10);
		repeat (20) @(negedge ref_clk);
		cmp("rx panel", 4'h0, {receiver_enable, panel_power, 2'b00});
	endtask : t_clock_loss
	task automatic t_supply_loss;
		t_run_up;
		host_supply_sense = 0;
		wait_st(4'h1, 6);
		cmp("outputs", {2'b00, PWR_OFF}, {receiver_enable, panel_power, display_power_state});
		repeat (20) @(negedge ref_clk);
		cmp("seq_state", 4'h1, seq_state);
	endtask : t_supply_loss
	task automatic complete_run;
		if (errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic t_reset;
		repeat (8) @(negedge ref_clk);
		cmp("outputs", {2'b00, PWR_OFF}, {receiver_enable, panel_power, display_power_state});
		rst = 0;
		repeat (2) @(negedge ref_clk);
		cmp("seq_state", 4'h1, seq_state);
	endtask : t_reset
	initial begin
		t_reset;
		t_discovery;
		t_clock_loss;
		t_supply_loss;
		complete_run;
	end
	// watchdog well past the expected few thousand cycles
	initial begin
		#200000;
		errors++;
		complete_run;
	end
endmodule : monitor_hotplug_power_sequencer_test
bind monitor_hotplug_power_sequencer hotplug_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
	.ref_clk(ref_clk),
	.rst(rst),
	.host_supply_sense(host_supply_sense),
	.pixel_shift_clock(pixel_shift_clock),
	.receiver_enable(receiver_enable),
	.panel_power(panel_power),
	.display_power_state(display_power_state),
	.seq_state(seq_state)
);

// ==== hw/hotplug_pkg.sv ====
// constants for the monitor hot-plug power sequencer
package hotplug_pkg;
	localparam logic [6:0] ID_DEV_ADDR = 7'h51; // A2h as 8-bit write address
	localparam int ID_BYTES = 256;
	localparam logic [8:0] ID_LAST_COUNT = 9'h100;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_TIMEOUT_NS = 2000;
	localparam int CLK_TIMEOUT_CYC = CLK_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int SYNC_TIMEOUT_NS = 40000;
	localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam logic [1:0] PWR_ON = 2'h0;
	localparam logic [1:0] PWR_STANDBY = 2'h1;
	localparam logic [1:0] PWR_SUSPEND = 2'h2;
	localparam logic [1:0] PWR_OFF = 2'h3;
	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_WAIT_ID = 4'b0010,
		ST_WAIT_CLK = 4'b0100,
		ST_NORMAL = 4'b1000
	} seq_state_t;
endpackage : hotplug_pkg

// ==== hw/monitor_hotplug_power_sequencer.sv ====
// monitor power-up and hot-plug sequencer
`timescale 1ns/1ns
module monitor_hotplug_power_sequencer
	import hotplug_pkg::*;
#(
	parameter int TIMEOUT_CYC = CLK_TIMEOUT_CYC,
	parameter int SYNC_CYC = SYNC_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// host pins
	input wire logic host_supply_sense,
	input wire logic pixel_shift_clock,
	input wire logic hsync,
	input wire logic vsync,
	// identification store read events, same clock
	input wire logic id_read_start,
	input wire logic [6:0] id_read_addr,
	input wire logic id_byte_read,
	input wire logic id_read_stop,
	// outputs
	output logic receiver_enable,
	output logic panel_power,
	output logic [1:0] display_power_state,
	output logic [3:0] seq_state
);
	seq_state_t state_reg;
	seq_state_t state_next;
	logic [1:0] supply_sync_reg;
	logic supply_ok;
	logic clock_present;
	logic reading_reg;
	logic [8:0] byte_cnt_reg;
	logic id_done_reg;
	// sync lines: index 0 horizontal, index 1 vertical
	logic [1:0] sync_pin;
	logic [1:0] sync_active;
	logic hs_active;
	logic vs_active;
	logic [1:0] power_next;

	shift_clock_watch #(
		.TIMEOUT_CYC(TIMEOUT_CYC)
	) u_watch (
		.ref_clk(ref_clk),
		.rst(rst),
		.pixel_shift_clock(pixel_shift_clock),
		.clock_present(clock_present)
	);

	// supply pin synchroniser
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			supply_sync_reg <= 2'h0;
		end else begin
			supply_sync_reg <= {supply_sync_reg[0], host_supply_sense};
		end
	end
	assign supply_ok = supply_sync_reg[1];

	// per sync line: synchroniser, edge detect and idle counter
	assign sync_pin = {vsync, hsync};
	for (genvar ch = 0; ch < 2; ch++) begin : g_sync
		logic [1:0] pin_sync_reg;
		logic pin_prev_reg;
		logic [19:0] idle_reg;
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				pin_sync_reg <= 2'h0;
			end else begin
				pin_sync_reg <= {pin_sync_reg[0], sync_pin[ch]};
			end
		end

		// only the second flop feeds the edge detector
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				pin_prev_reg <= 1'b0;
			end else begin
				pin_prev_reg <= pin_sync_reg[1];
			end
		end

		// saturates so a dead line reads idle until it toggles again
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				idle_reg <= 20'h0_0000;
			end else if (pin_sync_reg[1] != pin_prev_reg) begin
				idle_reg <= 20'h0_0000;
			end else if (idle_reg != 20'(SYNC_CYC)) begin
				idle_reg <= idle_reg + 20'h0_0001;
			end
		end
		assign sync_active[ch] = (idle_reg != 20'(SYNC_CYC));
	end
	assign hs_active = sync_active[0];
	assign vs_active = sync_active[1];

	// a read is followed only at the identification address
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reading_reg <= 1'b0;
		end else if (id_read_start) begin
			reading_reg <= (id_read_addr == ID_DEV_ADDR);
		end else if (id_read_stop) begin
			reading_reg <= 1'b0;
		end
	end

	// a partial read does not count; a restart begins again from zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			byte_cnt_reg <= 9'h000;
		end else if (id_read_start) begin
			byte_cnt_reg <= 9'h000;
		end else if (!id_read_stop && reading_reg && id_byte_read && byte_cnt_reg != ID_LAST_COUNT) begin
			byte_cnt_reg <= byte_cnt_reg + 9'h001;
		end
	end

	// set wins over the clear from the sequencer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			id_done_reg <= 1'b0;
		end else if (reading_reg && id_byte_read && byte_cnt_reg == ID_LAST_COUNT - 9'h001) begin
			id_done_reg <= 1'b1;
		end else if (state_reg == ST_OFF || !supply_ok) begin
			id_done_reg <= 1'b0;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: begin
				if (supply_ok) begin
					state_next = ST_WAIT_ID;
				end
			end
			ST_WAIT_ID: begin
				if (!supply_ok) begin
					state_next = ST_OFF;
				end else if (id_done_reg) begin
					state_next = ST_WAIT_CLK;
				end
			end
			ST_WAIT_CLK: begin
				if (!supply_ok) begin
					state_next = ST_OFF;
				end else if (clock_present) begin
					state_next = ST_NORMAL;
				end
			end
			ST_NORMAL: begin
				if (!supply_ok || !clock_present) begin
					state_next = ST_OFF;
				end
			end
			default: begin
				state_next = ST_OFF;
			end
		endcase
	end

	// one-hot state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs registered from next state so they track the state exactly
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			receiver_enable <= 1'b0;
		end else begin
			receiver_enable <= (state_next == ST_WAIT_CLK) || (state_next == ST_NORMAL);
		end
	end

	// panel drops on the same edge that leaves normal mode
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			panel_power <= 1'b0;
		end else begin
			panel_power <= (state_next == ST_NORMAL);
		end
	end

	// four-state power decode, only meaningful in normal mode
	always_comb begin
		power_next = PWR_OFF;
		if (state_next == ST_NORMAL) begin
			case ({hs_active, vs_active})
				2'h3: begin
					power_next = PWR_ON;
				end
				2'h1: begin
					power_next = PWR_STANDBY;
				end
				2'h2: begin
					power_next = PWR_SUSPEND;
				end
				default: begin
					power_next = PWR_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			display_power_state <= PWR_OFF;
		end else begin
			display_power_state <= power_next;
		end
	end

	assign seq_state = state_reg;
endmodule : monitor_hotplug_power_sequencer

// ==== hw/shift_clock_watch.sv ====
// shift clock presence detector across the link domain
`timescale 1ns/1ns
module shift_clock_watch
	import hotplug_pkg::*;
#(
	parameter int TIMEOUT_CYC = CLK_TIMEOUT_CYC
) (
	// local clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// link clock
	input wire logic pixel_shift_clock,
	// status
	output logic clock_present
);
	logic link_toggle_reg;
	logic [2:0] sync_reg;
	logic [15:0] idle_cnt_reg;
	// toggle per link edge; link clock may stand still, so no reset release needed there
	always_ff @(posedge pixel_shift_clock or posedge rst) begin
		if (rst) begin
			link_toggle_reg <= 1'b0;
		end else begin
			link_toggle_reg <= ~link_toggle_reg;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_reg <= 3'h0;
		end else begin
			sync_reg <= {sync_reg[1:0], link_toggle_reg};
		end
	end
	// link clock must be below ref rate for every edge to be seen
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idle_cnt_reg <= 16'h0000;
			clock_present <= 1'b0;
		end else if (sync_reg[2] != sync_reg[1]) begin
			idle_cnt_reg <= 16'h0000;
			clock_present <= 1'b1;
		end else if (idle_cnt_reg >= 16'(TIMEOUT_CYC - 1)) begin
			clock_present <= 1'b0;
		end else begin
			idle_cnt_reg <= idle_cnt_reg + 16'h0001;
		end
	end
endmodule : shift_clock_watch
